// [core/mscr_pkg.sv]
// Shared constants and types for the mode readback and system configuration registers
`default_nettype none
package mscr_pkg;
	// ------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_IDX      = 16'hfff1;  // Mode readback register index
	localparam logic [15:0] CFG_IDX       = 16'hfff2;  // System configuration register index
	localparam logic [31:0] MODE_ADDR     = {14'h0000, MODE_IDX, 2'h0};
	localparam logic [31:0] CFG_ADDR      = {14'h0000, CFG_IDX, 2'h0};

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  MODE_FIXED    = 8'hc4;     // Bits 7,6,2 read one, 5..3 read zero
	localparam logic [7:0]  CFG_RESET     = 8'h0b;     // Configuration reset value
	localparam logic [7:0]  CFG_WR_MASK   = 8'hfd;     // Writable configuration bits
	localparam logic [7:0]  CFG_RO_ONES   = 8'h02;     // Read-only bits that read one
	localparam int          CFG_STBY_SEL  = 7;         // Standby select bit
	localparam int          CFG_SET_LO    = 4;         // Settling select field, low bit
	localparam int          CFG_USER      = 3;         // Mask bit used as user bit
	localparam int          CFG_EDGE      = 2;         // Priority interrupt edge select
	localparam int          CFG_RAM_ON    = 0;         // On-chip RAM enable
	localparam logic [7:0]  RAM_OFF_READ  = 8'hff;     // Read value of disabled RAM

	// ------------------------------------------------------------
	// Modes and timing
	// ------------------------------------------------------------
	localparam logic [1:0]  MODE_EXP      = 2'h1;      // Mode 1: expanded, 1 Mbyte
	localparam logic [1:0]  MODE_NORMAL   = 2'h2;      // Mode 2: single chip, 64 kbyte
	localparam logic [1:0]  MODE_ADV      = 2'h3;      // Mode 3: single chip, 1 Mbyte
	localparam logic [1:0]  MODE_RESET    = 2'h0;      // Mode latch value under reset
	localparam int          SETTLE_BASE   = 8192;      // Shortest settling wait in states
	localparam logic [2:0]  SETTLE_SH_MAX = 3'h4;      // Shift for code 10x
	localparam int          SETTLE_W      = 18;        // Wide enough for 131072
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SEL_NONE, SEL_MODE, SEL_CFG} mscr_sel_e;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} mscr_ahb_req_s;
endpackage
`default_nettype wire

// [core/mscr_ahb_decode.sv]
// AHB-Lite address phase decode and write data phase tracking
`default_nettype none
module mscr_ahb_decode (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// Address phase
	input  wire mscr_pkg::mscr_ahb_req_s req,
	// Decoded strobes
	output logic                        rd_take,
	output mscr_pkg::mscr_sel_e         rd_sel,
	output logic                        wr_pend,
	output mscr_pkg::mscr_sel_e         wr_sel
);
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Only aligned word hits select a register; anything else is unmapped
	function automatic mscr_pkg::mscr_sel_e decode(input logic [31:0] a);
		if (a == mscr_pkg::MODE_ADDR) begin
			return mscr_pkg::SEL_MODE;
		end else if (a == mscr_pkg::CFG_ADDR) begin
			return mscr_pkg::SEL_CFG;
		end
		return mscr_pkg::SEL_NONE;
	endfunction

	logic take;  // Address phase accepted this edge
	assign take    = req.hsel && req.hready && (req.htrans == mscr_pkg::HTRANS_NONSEQ);
	assign rd_take = take && !req.hwrite;
	assign rd_sel  = decode(req.haddr);

	// Write waits for its data phase, which follows one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_sel  <= mscr_pkg::SEL_NONE;
		end else begin
			wr_pend <= take && req.hwrite;
			wr_sel  <= decode(req.haddr);
		end
	end
endmodule
`default_nettype wire

// [core/mscr_edge_det.sv]
// Selectable edge detector for the priority interrupt pin
`default_nettype none
module mscr_edge_det (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Pin and edge choice
	input  wire logic pin,
	input  wire logic rising_sel,
	// Detected edge, combinational
	output logic      edge_seen
);
	logic prev;   // Pin level one cycle ago
	logic armed;  // Low for the first cycle after reset so no request comes at once

	// Previous level and arming
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev  <= 1'b1;
			armed <= 1'b0;
		end else begin
			prev  <= pin;
			armed <= 1'b1;
		end
	end

	// Rising when selected, falling otherwise
	assign edge_seen = armed && (rising_sel ? (pin && !prev) : (!pin && prev));
endmodule
`default_nettype wire

// [core/mscr_regs.sv]
// Mode readback and system configuration registers with mode-dependent pin control
// How it works
// - Eight-bit read-only mode readback register
// - Readback upper bits fixed at 110001
// - Low two bits report mode pins
// - Mode pins latched when readback is read
// - Configuration register, read/write, resets to 0x0b
// - Bit 7 picks sleep or standby
// - Standby select kept after interrupt wake
// - Bits 6..4 select settling wait length
// - Bit 3 makes mask bit user bit
// - Bit 2 picks priority interrupt edge
// - Bit 1 read-only, reads one
// - Bit 0 enables RAM, kept in standby
// - Mode 1: external data and address
// - Address pins drive only once direction set
// - Mode 2: 64 kbyte, internal only
// - Mode 3: 1 Mbyte, internal only
// - Disabled RAM: read 0xff or external
//
// The AHB-Lite slave port is this design's own decision.
`default_nettype none
module mscr_regs #(
	parameter int unsigned SETTLE_BASE_STATES = mscr_pkg::SETTLE_BASE  // Shorten in simulation
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Mode pins
	input  wire logic        mode_pin_hi,
	input  wire logic        mode_pin_lo,
	// CPU events
	input  wire logic        sleep_exec,
	input  wire logic        wake_irq,
	input  wire logic        nmi_pin,
	// Port direction bits of ports 1, 2, 5
	input  wire logic [19:0] port_ddr,
	// Configuration outputs
	output logic             mask_bit_as_user,
	output logic             priority_irq_edge_sel,
	output logic             onchip_ram_on,
	output logic             nmi_request,
	// Power state
	output logic             in_sleep,
	output logic             in_standby,
	output logic             settling,
	// Mode-dependent pin and memory control
	output logic             ext_bus_on,
	output logic             wide_space,
	output logic [19:0]      addr_pin_drive,
	output logic             ram_ext_space,
	output logic             ram_read_ff
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STANDBY, PWR_SETTLE} mscr_pwr_e;

	mscr_pkg::mscr_ahb_req_s req;       // Bundled address phase
	mscr_pkg::mscr_sel_e     rd_sel;    // Register addressed by a read
	mscr_pkg::mscr_sel_e     wr_sel;    // Register addressed by a pending write
	logic                    rd_take;   // Read accepted this edge
	logic                    wr_pend;   // Write data phase this cycle
	logic                    nmi_edge;  // Chosen edge seen on the pin
	logic [7:0]              sys_config;
	logic [7:0]              next_cfg;
	logic [1:0]              mode_latch;  // Pins caught at the last readback read
	logic [1:0]              mode_now;    // Running copy of the pins for pin control
	mscr_pwr_e               pwr;
	logic [mscr_pkg::SETTLE_W-1:0] settle_cnt;
	logic [mscr_pkg::SETTLE_W-1:0] settle_limit;  // Length chosen at wake

	assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hready: hready};

	// Settling length from the three-bit code; 11x is not allowed and is treated as 10x
	function automatic logic [mscr_pkg::SETTLE_W-1:0] settle_len(input logic [2:0] code);
		logic [2:0] sh;
		sh = code[2] ? mscr_pkg::SETTLE_SH_MAX : {1'b0, code[1:0]};
		return mscr_pkg::SETTLE_W'(SETTLE_BASE_STATES << sh);
	endfunction

	// ------------------------------------------------------------
	// Bus decode and edge detector
	// ------------------------------------------------------------
	mscr_ahb_decode u_decode (
		.hclk    (hclk),
		.hresetn (hresetn),
		.req     (req),
		.rd_take (rd_take),
		.rd_sel  (rd_sel),
		.wr_pend (wr_pend),
		.wr_sel  (wr_sel)
	);

	mscr_edge_det u_nmi (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pin        (nmi_pin),
		.rising_sel (sys_config[mscr_pkg::CFG_EDGE]),
		.edge_seen  (nmi_edge)
	);

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// Next value, so a read right behind a write sees the new contents
	always_comb begin
		next_cfg = sys_config;
		if (wr_pend && wr_sel == mscr_pkg::SEL_CFG) begin
			// Bit 1 is forced, other bits take the written byte
			next_cfg = (hwdata[7:0] & mscr_pkg::CFG_WR_MASK) | mscr_pkg::CFG_RO_ONES;
		end
	end

	// Only software writes change it; a wake from standby leaves bit 7 and bit 0 alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_config <= mscr_pkg::CFG_RESET;
		end else begin
			sys_config <= next_cfg;
		end
	end

	assign mask_bit_as_user      = sys_config[mscr_pkg::CFG_USER];
	assign priority_irq_edge_sel = sys_config[mscr_pkg::CFG_EDGE];
	assign onchip_ram_on         = sys_config[mscr_pkg::CFG_RAM_ON];

	// ------------------------------------------------------------
	// Mode pins
	// ------------------------------------------------------------
	// Readback field is caught at the read, not tracked continuously
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_latch <= mscr_pkg::MODE_RESET;
		end else if (rd_take && rd_sel == mscr_pkg::SEL_MODE) begin
			mode_latch <= {mode_pin_hi, mode_pin_lo};
		end
	end

	// Pins are held steady by the board, so a plain sample serves the pin control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_now <= mscr_pkg::MODE_RESET;
		end else begin
			mode_now <= {mode_pin_hi, mode_pin_lo};
		end
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	// Zero wait states; read data is formed at the address phase and held in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_take) begin
				unique case (rd_sel)
					mscr_pkg::SEL_MODE: begin
						hrdata <= {24'h000000, mscr_pkg::MODE_FIXED | {6'h00, mode_pin_hi, mode_pin_lo}};
					end
					mscr_pkg::SEL_CFG: begin
						hrdata <= {24'h000000, next_cfg};
					end
					mscr_pkg::SEL_NONE: begin
						// Unmapped reads return zero
						hrdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Power state and settling counter
	// ------------------------------------------------------------
	// Sleep wakes on any interrupt; standby waits for the oscillator before running
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr          <= PWR_RUN;
			settle_cnt   <= '0;
			settle_limit <= '0;
		end else begin
			unique case (pwr)
				PWR_RUN: begin
					if (sleep_exec) begin
						pwr <= sys_config[mscr_pkg::CFG_STBY_SEL] ? PWR_STANDBY : PWR_SLEEP;
					end
				end
				PWR_SLEEP: begin
					if (wake_irq) begin
						pwr <= PWR_RUN;
					end
				end
				PWR_STANDBY: begin
					if (wake_irq) begin
						pwr          <= PWR_SETTLE;
						settle_cnt   <= '0;
						settle_limit <= settle_len(sys_config[mscr_pkg::CFG_SET_LO +: 3]);
					end
				end
				PWR_SETTLE: begin
					// Counts states until the chosen length is reached
					if (settle_cnt == settle_limit - 1'b1) begin
						pwr <= PWR_RUN;
					end
					settle_cnt <= settle_cnt + 1'b1;
				end
			endcase
		end
	end

	// Power outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_sleep    <= 1'b0;
			in_standby  <= 1'b0;
			settling    <= 1'b0;
			nmi_request <= 1'b0;
		end else begin
			in_sleep    <= (pwr == PWR_SLEEP);
			in_standby  <= (pwr == PWR_STANDBY);
			settling    <= (pwr == PWR_SETTLE);
			nmi_request <= nmi_edge;
		end
	end

	// ------------------------------------------------------------
	// Mode-dependent pins and RAM routing
	// ------------------------------------------------------------
	// Address pins stay ports until direction bits are set, and only in mode 1
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_bus_on     <= 1'b0;
			wide_space     <= 1'b0;
			addr_pin_drive <= 20'h00000;
			ram_ext_space  <= 1'b0;
			ram_read_ff    <= 1'b0;
		end else begin
			ext_bus_on     <= (mode_now == mscr_pkg::MODE_EXP);
			wide_space     <= (mode_now == mscr_pkg::MODE_EXP) || (mode_now == mscr_pkg::MODE_ADV);
			addr_pin_drive <= (mode_now == mscr_pkg::MODE_EXP) ? port_ddr : 20'h00000;
			ram_ext_space  <= (mode_now == mscr_pkg::MODE_EXP) && !sys_config[mscr_pkg::CFG_RAM_ON];
			ram_read_ff    <= (mode_now == mscr_pkg::MODE_NORMAL || mode_now == mscr_pkg::MODE_ADV)
			                  && !sys_config[mscr_pkg::CFG_RAM_ON];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_read_mode;
		rd_take && rd_sel == mscr_pkg::SEL_MODE;
	endsequence

	sequence s_write_mode;
		wr_pend && wr_sel == mscr_pkg::SEL_MODE;
	endsequence

	a_mode_fixed_bits: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_mode |=> hrdata[31:2] == {24'h000000, mscr_pkg::MODE_FIXED[7:2]})
		else $error("mode readback fixed bits wrong");

	a_mode_pin_catch: assert property (@(posedge hclk) disable iff (!hresetn)
		s_read_mode |=> hrdata[1:0] == $past({mode_pin_hi, mode_pin_lo}) && mode_latch == hrdata[1:0])
		else $error("mode pins not caught at read");

	a_cfg_bit_one: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_take && rd_sel == mscr_pkg::SEL_CFG |=> hrdata[1] && sys_config[1])
		else $error("config bit 1 not one");

	a_ro_write_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		s_write_mode |=> $stable(sys_config))
		else $error("mode register write had an effect");

	a_sleep_choice: assert property (@(posedge hclk) disable iff (!hresetn)
		pwr == PWR_RUN && sleep_exec |=> pwr == ($past(sys_config[7]) ? PWR_STANDBY : PWR_SLEEP) ##1
		(in_standby == $past(sys_config[7], 2)))
		else $error("sleep entered wrong state");

	a_standby_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		pwr == PWR_STANDBY && wake_irq && !wr_pend |=> sys_config[7] == $past(sys_config[7]))
		else $error("standby select lost at wake");

	a_settle_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(settling) |-> $past(settle_cnt, 2) == settle_limit - 1'b1)
		else $error("settling wait wrong length");

	a_nmi_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(nmi_pin) && sys_config[2] && $past(hresetn) |=> nmi_request)
		else $error("priority interrupt edge missed");

	a_addr_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 addr_pin_drive == ($past(mode_now) == mscr_pkg::MODE_EXP ? $past(port_ddr) : 20'h00000))
		else $error("address pins driven wrongly");

	a_ram_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_now == mscr_pkg::MODE_NORMAL && !sys_config[0] |=> ram_read_ff && !ram_ext_space)
		else $error("disabled RAM not blocked");
endmodule
`default_nettype wire

// [dv/mscr_pin_model.sv]
// Board-side model that straps the mode pins of the block
`default_nettype none
module mscr_pin_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Mode wanted by the bench
	input  wire logic [1:0] mode_code,
	// Mode pins
	output var  logic       mode_pin_hi,
	output var  logic       mode_pin_lo
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Strap logic
	// ----------------------------------------
	// Start strapped to mode 1, a legal setting
	initial begin
		mode_pin_hi = 1'b0;
		mode_pin_lo = 1'b1;
	end
	// Straps move only while reset is held and never to 00
	always @(posedge hclk) begin
		if (!hresetn && mode_code != 2'h0) begin
			mode_pin_hi <= mode_code[1];
			mode_pin_lo <= mode_code[0];
		end
	end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the mode readback and configuration registers
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [19:0] DDR = 20'h5a3c1;  // Direction bits seen in mode 1
	logic        hclk, hresetn;               // Clock and active-low reset
	logic        hsel, hwrite;                // Bus controls
	logic [31:0] haddr, hwdata, hrdata;       // Bus address and data
	logic [1:0]  htrans;                      // Transfer type
	logic [2:0]  hsize;                       // Always a word
	logic        hreadyout, hresp;            // Slave answer
	logic [1:0]  mode_code;                   // Mode asked of the pin model
	logic        mode_pin_hi, mode_pin_lo;    // Straps
	logic        sleep_exec, wake_irq, nmi_pin;
	logic [19:0] port_ddr;
	logic        mask_bit_as_user, priority_irq_edge_sel, onchip_ram_on, nmi_request;
	logic        in_sleep, in_standby, settling;
	logic        ext_bus_on, wide_space, ram_ext_space, ram_read_ff;
	logic [19:0] addr_pin_drive;
	logic [31:0] q;                           // Last read value
	int          n_errors, checked;           // Mismatch and compare counters
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	// Short settling base keeps standby runs brief
	mscr_regs #(.SETTLE_BASE_STATES(8)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo),
		.sleep_exec(sleep_exec), .wake_irq(wake_irq), .nmi_pin(nmi_pin), .port_ddr(port_ddr),
		.mask_bit_as_user(mask_bit_as_user), .priority_irq_edge_sel(priority_irq_edge_sel),
		.onchip_ram_on(onchip_ram_on), .nmi_request(nmi_request), .in_sleep(in_sleep),
		.in_standby(in_standby), .settling(settling), .ext_bus_on(ext_bus_on),
		.wide_space(wide_space), .addr_pin_drive(addr_pin_drive),
		.ram_ext_space(ram_ext_space), .ram_read_ff(ram_read_ff)
	);
	mscr_pin_model pins (
		.hclk(hclk), .hresetn(hresetn), .mode_code(mode_code),
		.mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo)
	);
	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	// Compare and count; case equality so unknowns never match
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Step past edges, then sample settled outputs
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	// Bounded wait for the slave to be ready at an edge
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 16);
		if (hreadyout !== 1'b1) begin
			chk("bus ready", 32'h0, 32'h1);
			results();
		end
	endtask
	// One single word transfer: address phase then data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= mscr_pkg::HTRANS_NONSEQ;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		// Read data and response are taken at the edge that ends the data phase
		q = hrdata;
		chk("bus response", hresp, 32'h0);
		#1;
	endtask
	// Power-state output picked by index
	function automatic logic pw(input int k);
		case (k)
			0: return in_sleep;
			1: return in_standby;
			default: return settling;
		endcase
	endfunction
	// Bounded wait for a power-state output to reach a level
	task automatic wait_pw(input int k, input logic v);
		int i;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (pw(k) !== v && i < 8);
		if (pw(k) !== v) begin
			chk("power state wait", 32'h0, 32'h1);
			results();
		end
	endtask
	// One-cycle pulse on sleep_exec (k=0) or wake_irq (k=1)
	task automatic pulse(input int k);
		@(posedge hclk);
		if (k == 1) wake_irq <= 1'b1;
		else sleep_exec <= 1'b1;
		@(posedge hclk);
		wake_irq <= 1'b0;
		sleep_exec <= 1'b0;
	endtask
	// Reset with a new strap; reset held three cycles
	task automatic do_reset(input logic [1:0] m);
		@(posedge hclk);
		hresetn <= 1'b0;
		mode_code <= m;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Each mode: reset values, latch on read, pin and RAM control
	task automatic t_modes();
		for (int m = 1; m < 4; m++) begin
			do_reset(m[1:0]);
			tick(1);
			chk("ext bus after reset", ext_bus_on, 32'h0);
			bus(1'b0, mscr_pkg::CFG_ADDR, 32'h0);
			chk("cfg reset", q, 32'h0000000b);
			chk("user bit reset", mask_bit_as_user, 32'h1);
			chk("edge sel reset", priority_irq_edge_sel, 32'h0);
			chk("ram on reset", onchip_ram_on, 32'h1);
			bus(1'b0, mscr_pkg::MODE_ADDR, 32'h0);
			chk("mode readback", q, 32'h000000c4 | m);
			tick(2);
			chk("ext bus", ext_bus_on, m == 1);
			chk("wide space", wide_space, m != 2);
			chk("addr drive", addr_pin_drive, (m == 1) ? DDR : 20'h0);
			bus(1'b1, mscr_pkg::CFG_ADDR, 32'h0000000a);
			tick(2);
			chk("ram off", onchip_ram_on, 32'h0);
			chk("ram external", ram_ext_space, m == 1);
			chk("ram reads ff", ram_read_ff, m != 1);
		end
	endtask
	// Read-only bits, ignored writes, unmapped place (strapped mode 3)
	task automatic t_regs();
		// Settling code 100 keeps clear of the illegal 11x codes
		bus(1'b1, mscr_pkg::CFG_ADDR, 32'hffffff45);
		chk("user bit", mask_bit_as_user, 32'h0);
		chk("edge sel", priority_irq_edge_sel, 32'h1);
		bus(1'b0, mscr_pkg::CFG_ADDR, 32'h0);
		chk("cfg written", q, 32'h00000047);
		bus(1'b1, mscr_pkg::CFG_ADDR, 32'h0);
		bus(1'b0, mscr_pkg::CFG_ADDR, 32'h0);
		chk("cfg fixed bit", q, 32'h00000002);
		bus(1'b1, mscr_pkg::MODE_ADDR, 32'h0);
		bus(1'b0, mscr_pkg::MODE_ADDR, 32'h0);
		chk("mode after write", q, 32'h000000c7);
		bus(1'b0, 32'h00000100, 32'h0);
		chk("unmapped read", q, 32'h0);
	endtask
	// Move the interrupt pin and count request pulses
	task automatic nmi_step(input logic v, input int exp);
		int n;
		@(posedge hclk);
		nmi_pin <= v;
		n = 0;
		repeat (4) begin
			tick(1);
			if (nmi_request === 1'b1) n++;
		end
		chk("nmi pulses", n, exp);
	endtask
	// Standby entry, wake, settling length, bits kept
	task automatic t_standby(input logic [2:0] code);
		int n;
		bus(1'b1, mscr_pkg::CFG_ADDR, {24'h0, 1'b1, code, 4'hb});
		pulse(0);
		wait_pw(1, 1'b1);
		chk("no sleep in standby", in_sleep, 32'h0);
		pulse(1);
		wait_pw(2, 1'b1);
		n = 0;
		while (settling === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("settle length", n, 8 << code);
		bus(1'b0, mscr_pkg::CFG_ADDR, 32'h0);
		chk("cfg kept", q, {24'h0, 1'b1, code, 4'hb});
	endtask
	// Sleep with standby select clear
	task automatic t_sleep();
		bus(1'b1, mscr_pkg::CFG_ADDR, 32'h0000000b);
		pulse(0);
		wait_pw(0, 1'b1);
		chk("no standby in sleep", in_standby, 32'h0);
		pulse(1);
		wait_pw(0, 1'b0);
	endtask
	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, sleep_exec, wake_irq} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = mscr_pkg::HSIZE_WORD;
		nmi_pin = 1'b1;
		port_ddr = DDR;
		mode_code = 2'h1;
		n_errors = 0;
		checked = 0;
		t_modes();
		t_regs();
		bus(1'b1, mscr_pkg::CFG_ADDR, 32'h0000000b);
		nmi_step(1'b0, 1);
		nmi_step(1'b1, 0);
		bus(1'b1, mscr_pkg::CFG_ADDR, 32'h0000000f);
		nmi_step(1'b0, 0);
		nmi_step(1'b1, 1);
		t_sleep();
		// Legal settling codes only; 11x is never programmed
		for (int c = 0; c < 5; c++) begin
			t_standby(c[2:0]);
		end
		results();
	end
endmodule
`default_nettype wire
